// ==== dv/mris_ref_source.sv ====
// far-side speed reference source: square wave on the speed pin
`timescale 1ns/1ps
module mris_ref_source (
  input wire logic mclk,
  input wire logic enable,
  input wire logic [15:0] highCycles,
  input wire logic [15:0] periodCycles,
  output logic speedPin
);
  logic [15:0] phase_q;
  // pin rests low while the source is off, a zero reference
  always @(posedge mclk) begin
    if (!enable) begin
      phase_q <= #2 16'h0000;
      speedPin <= #2 1'b0;
    end else begin
      phase_q <= #2 (phase_q + 16'h0001 >= periodCycles) ? 16'h0000 : phase_q + 16'h0001;
      speedPin <= #2 (phase_q < highCycles);
    end
  end
endmodule

// ==== dv/mris_top_test.sv ====
// self-checking bench for the motor reference input selector
`timescale 1ns/1ps
module mris_top_test;
  import mris_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic speedPin;
  logic [11:0] analogLevel = 12'h000;
  logic analogValid = 1'b0;
  logic [1:0] sourceSelect = 2'h0;
  logic [1:0] bandSelect = 2'h0;
  logic [1:0] profileSelect = 2'h0;
  logic closed_loop_select = 1'b0;
  logic [11:0] analog_full_scale = 12'h0ff;
  logic [15:0] maxFreqPeriod = 16'h0064;
  logic [7:0] standby_entry_level = 8'h10;
  logic [7:0] standby_exit_level = 8'h20;
  logic [11:0] sleep_entry_level = 12'h200;
  logic [11:0] sleep_exit_level = 12'h400;
  logic [7:0] hostCommand = 8'h00;
  logic hostWrite = 1'b0;
  logic [15:0] idleDelayUs = 16'h0002;
  logic [15:0] maxSpeed = 16'h00ff;
  logic [15:0] current_ceiling = 16'h01fe;
  logic [7:0] command_deadband = 8'h08;
  logic [7:0] dutyCmd;
  logic dutyValid;
  logic [15:0] speedTarget;
  logic [15:0] currentTarget;
  logic speedLoopOn;
  logic currentLoopOn;
  logic shapedProfile;
  logic stopReq;
  logic standbyOn;
  logic sleepOn;
  logic genOn = 1'b0;
  logic [15:0] genHigh = 16'h0000;
  logic [15:0] genPeriod = 16'h0001;
  int error_cnt = 0;
  int total_checks = 0;
  int n;

  always #25 mclk = ~mclk;

  mris_top mris_top_inst (.mclk, .sys_rst, .speedPin, .analogLevel, .analogValid,
    .sourceSelect, .bandSelect, .profileSelect, .closed_loop_select, .analog_full_scale,
    .maxFreqPeriod, .standby_entry_level, .standby_exit_level, .sleep_entry_level,
    .sleep_exit_level, .hostCommand, .hostWrite, .idleDelayUs, .maxSpeed, .current_ceiling,
    .command_deadband, .dutyCmd, .dutyValid, .speedTarget, .currentTarget, .speedLoopOn,
    .currentLoopOn, .shapedProfile, .stopReq, .standbyOn, .sleepOn);

  mris_ref_source mris_ref_source_inst (.mclk, .enable(genOn), .highCycles(genHigh),
    .periodCycles(genPeriod), .speedPin);

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // every drive lands 2 ns after a rising edge
  task automatic tick(input int cyc);
    repeat (cyc) @(posedge mclk);
    #2;
  endtask

  function automatic logic flag(input int k);
    case (k)
      0: return dutyValid;
      1: return stopReq;
      2: return sleepOn;
      default: return standbyOn;
    endcase
  endfunction

  task automatic wait_hi(input int k, input int lim, output int cnt);
    cnt = 0;
    while (flag(k) !== 1'b1 && cnt < lim) begin
      tick(1);
      cnt++;
    end
    if (cnt >= lim) begin
      error_cnt++;
      $display("MISMATCH flag %0d expected 1 seen 0", k);
      wrap_up();
    end
  endtask

  task automatic sample(input logic [11:0] level);
    analogLevel = level;
    analogValid = 1'b1;
    tick(1);
    analogValid = 1'b0;
  endtask

  // analog sample, then duty pulse and value one cycle later, targets one more
  task automatic ana(input logic [11:0] level, input logic [7:0] exp);
    sample(level);
    check("dutyValid", {15'h0000, dutyValid}, 16'h0001);
    check("dutyCmd", {8'h00, dutyCmd}, {8'h00, exp});
    tick(1);
  endtask

  task automatic host(input logic [7:0] cmd);
    hostCommand = cmd;
    hostWrite = 1'b1;
    tick(1);
    hostWrite = 1'b0;
    check("hostDuty", {7'h00, dutyValid, dutyCmd}, {8'h01, cmd});
    tick(1);
  endtask

  // run the source until the third update so a partial first period drops out
  task automatic pin_run(input logic [15:0] hi, input logic [15:0] per);
    genHigh = hi;
    genPeriod = per;
    genOn = 1'b1;
    repeat (3) begin
      wait_hi(0, 5000, n);
      tick(1);
    end
    genOn = 1'b0;
    // let the source rest one edge so the next run restarts its phase
    tick(1);
  endtask

  initial begin
    tick(16);
    sys_rst = 1'b0;
    check("speedLoopOn", {15'h0000, speedLoopOn}, 16'h0001);
    ana(12'h080, 8'h80);
    check("speedTarget", speedTarget, 16'h0080);
    ana(12'h084, 8'h84);
    check("speedTarget", speedTarget, 16'h0080);
    ana(12'h300, 8'hff);
    check("speedTarget", speedTarget, 16'h00ff);
    ana(12'h008, 8'h00);
    check("speedTarget", speedTarget, TGT_ZERO);
    ana(12'h018, 8'h00);
    check("stopEarly", {15'h0000, stopReq}, 16'h0000);
    wait_hi(1, 300, n);
    check("idleSpan", {15'h0000, (n >= 30 && n <= 100)}, 16'h0001);
    closed_loop_select = 1'b1;
    tick(1);
    check("loops", {14'h0000, speedLoopOn, currentLoopOn}, 16'h0001);
    ana(12'h040, 8'h40);
    check("currentTarget", currentTarget, 16'h0080);
    profileSelect = 2'h1;
    ana(12'h0a0, 8'ha0);
    check("shaped", {shapedProfile, currentTarget[14:0]}, 16'h8000);
    profileSelect = PROF_DIRECT;
    closed_loop_select = 1'b0;
    sourceSelect = SRC_HOST;
    sample(12'h100);
    host(8'h60);
    host(8'h00);
    wait_hi(2, 400, n);
    check("sleepStop", {15'h0000, stopReq}, 16'h0001);
    sample(12'h800);
    tick(2);
    check("sleepOn", {15'h0000, sleepOn}, 16'h0000);
    wait_hi(3, 20, n);
    check("standbyDuty", {8'h00, dutyCmd}, 16'h0000);
    host(8'h60);
    check("wakeRun", {15'h0000, standbyOn}, 16'h0000);
    sourceSelect = SRC_PWM;
    idleDelayUs = 16'h0028;
    pin_run(16'h0064, 16'h00ff);
    check("pwmDuty", {8'h00, dutyCmd}, 16'h0064);
    check("pwmNoStop", {15'h0000, stopReq}, 16'h0000);
    bandSelect = 2'h1;
    pin_run(16'h0190, 16'h03fc);
    check("bandDuty", {15'h0000, (dutyCmd >= 8'h63 && dutyCmd <= 8'h65)}, 16'h0001);
    bandSelect = 2'h2;
    pin_run(16'h0140, 16'h0330);
    check("band2Duty", {8'h00, dutyCmd}, 16'h0064);
    bandSelect = 2'h0;
    sourceSelect = SRC_FREQ;
    pin_run(16'h0096, 16'h012c);
    check("freqDuty", {8'h00, dutyCmd}, 16'h0055);
    pin_run(16'h0019, 16'h0032);
    check("freqClamp", {8'h00, dutyCmd}, {8'h00, DUTY_FULL});
    wrap_up();
  end
endmodule

// ==== rtl/mris_pkg.sv ====
// constants for the motor reference input selector
package mris_pkg;
  localparam int CLK_NS = 50;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_NS;
  localparam logic [4:0] US_LAST = 5'(CYC_PER_US - 1);
  localparam logic [1:0] SRC_ANALOG = 2'h0;
  localparam logic [1:0] SRC_PWM = 2'h1;
  localparam logic [1:0] SRC_HOST = 2'h2;
  localparam logic [1:0] SRC_FREQ = 2'h3;
  localparam logic [1:0] PROF_DIRECT = 2'h0;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] TGT_ZERO = 16'h0000;
  localparam logic [7:0] PRESC_ZERO = 8'h00;
  localparam logic [4:0] US_ZERO = 5'h00;
  localparam logic [11:0] LVL_ZERO = 12'h000;
  localparam logic [23:0] FULL_SCALE = 24'h0000_ff;
  // band prescaler divisors for pwm and frequency inputs
  localparam logic [7:0] DIV_BAND0 = 8'h01;
  localparam logic [7:0] DIV_BAND1 = 8'h04;
  localparam logic [7:0] DIV_BAND2 = 8'h10;
  localparam logic [7:0] DIV_BAND3 = 8'h40;
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_STANDBY = 3'b010,
    PWR_SLEEP = 3'b100
  } mris_pwr_e;
endpackage

// ==== rtl/mris_top.sv ====
// motor reference source selection, duty command and setpoint mapping
//
// Operation
// - loop select low: reference becomes speed target for the speed loop
// - loop select high: reference becomes quadrature current target
// - source 00: analog level to duty, zero in standby, clamped at full scale
// - source 01: measured pin duty to command, zero in standby
// - pwm input band chosen by band select, independent of motor switching
// - source 10: host writes command register, device derives duty from it
// - host mode: sleep if pin below sleep entry after long zero command
// - host mode: wake when pin exceeds sleep exit, then follow register
// - host mode: standby while command low and pin above sleep exit
// - source 11: pin frequency to duty, clamped above maximum frequency
// - zero pin input waits the idle delay before requesting stop
// - two-bit profile picks direct mapping or shaped external curves
// - direct profile: target is duty times maximum speed or current ceiling
// - direct profile: target changes only when duty moves by the deadband or drops to zero
// - zero reference stops the motor for every profile
`timescale 1ns/1ps
module mris_top
  import mris_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic speedPin,
  input wire logic [11:0] analogLevel,
  input wire logic analogValid,
  input wire logic [1:0] sourceSelect,
  input wire logic [1:0] bandSelect,
  input wire logic [1:0] profileSelect,
  input wire logic closed_loop_select,
  input wire logic [11:0] analog_full_scale,
  input wire logic [15:0] maxFreqPeriod,
  input wire logic [7:0] standby_entry_level,
  input wire logic [7:0] standby_exit_level,
  input wire logic [11:0] sleep_entry_level,
  input wire logic [11:0] sleep_exit_level,
  input wire logic [7:0] hostCommand,
  input wire logic hostWrite,
  input wire logic [15:0] idleDelayUs,
  input wire logic [15:0] maxSpeed,
  input wire logic [15:0] current_ceiling,
  input wire logic [7:0] command_deadband,
  output logic [7:0] dutyCmd,
  output logic dutyValid,
  output logic [15:0] speedTarget,
  output logic [15:0] currentTarget,
  output logic speedLoopOn,
  output logic currentLoopOn,
  output logic shapedProfile,
  output logic stopReq,
  output logic standbyOn,
  output logic sleepOn
);
  logic syncA_q, syncB_q, syncC_q;
  logic [7:0] prescCnt_q;
  logic [15:0] hiCnt_q, perCnt_q, hiLat_q, perLat_q;
  logic stale_q, measValid_q;
  logic sb_q;
  logic [7:0] duty_q, lastDuty_q;
  logic dutyValid_q;
  logic [15:0] spd_q, cur_q;
  logic [4:0] usCnt_q;
  logic [15:0] idleCnt_q;
  logic idleDone_q;
  logic [11:0] pinLvl_q;
  mris_pwr_e pwr_q, pwr_d;

  wire rise = syncB_q & ~syncC_q;
  wire [7:0] bandDiv = (bandSelect == 2'h0) ? DIV_BAND0 :
                       (bandSelect == 2'h1) ? DIV_BAND1 :
                       (bandSelect == 2'h2) ? DIV_BAND2 : DIV_BAND3;
  wire tick = (prescCnt_q == 8'(bandDiv - 8'h01));
  wire perSat = (perCnt_q == CNT_MAX);
  wire srcPin = (sourceSelect == SRC_PWM) || (sourceSelect == SRC_FREQ);
  wire timeout = srcPin && perSat && !stale_q;

  // shared divider: numerator and denominator per source
  wire [23:0] numAna = 24'(analogLevel) * FULL_SCALE;
  wire [23:0] numPwm = 24'(hiLat_q) * FULL_SCALE;
  wire [23:0] numFrq = 24'(maxFreqPeriod) * FULL_SCALE;
  wire [23:0] num = (sourceSelect == SRC_ANALOG) ? numAna :
                    (sourceSelect == SRC_PWM) ? numPwm : numFrq;
  wire [15:0] denRaw = (sourceSelect == SRC_ANALOG) ? 16'(analog_full_scale) : perLat_q;
  wire [15:0] den = (denRaw == CNT_ZERO) ? CNT_ONE : denRaw;
  wire [23:0] quot = num / 24'(den);
  wire clampAna = (analogLevel >= analog_full_scale);
  wire clampPwm = (hiLat_q >= perLat_q);
  wire clampFrq = (perLat_q <= maxFreqPeriod);
  wire clampHit = (sourceSelect == SRC_ANALOG) ? clampAna :
                  (sourceSelect == SRC_PWM) ? clampPwm : clampFrq;
  wire [7:0] measDuty = clampHit ? DUTY_FULL : quot[7:0];
  // a dead pin: pwm reads its level as 0 or 100 %, frequency reads zero
  wire [7:0] staleDuty = (sourceSelect == SRC_PWM && syncB_q) ? DUTY_FULL : DUTY_ZERO;
  wire [7:0] rawDuty = (sourceSelect == SRC_HOST) ? hostCommand :
                       timeout ? staleDuty : measDuty;
  wire update = (sourceSelect == SRC_ANALOG) ? analogValid :
                (sourceSelect == SRC_HOST) ? hostWrite :
                (measValid_q || timeout);
  // standby hysteresis between entry and exit levels
  wire sbNext = (rawDuty <= standby_entry_level) ? 1'b1 :
                (rawDuty >= standby_exit_level) ? 1'b0 : sb_q;
  wire [7:0] dutyNext = sbNext ? DUTY_ZERO : rawDuty;

  wire [7:0] dutyDiff = (duty_q >= lastDuty_q) ? 8'(duty_q - lastDuty_q)
                                                : 8'(lastDuty_q - duty_q);
  wire accept = dutyValid_q && ((dutyDiff >= command_deadband) ||
                                (duty_q == DUTY_ZERO));
  wire isDirect = (profileSelect == PROF_DIRECT);
  wire [23:0] spdProd = 24'(duty_q) * 24'(maxSpeed);
  wire [23:0] curProd = 24'(duty_q) * 24'(current_ceiling);
  wire [15:0] spdMap = 16'(spdProd / FULL_SCALE);
  wire [15:0] curMap = 16'(curProd / FULL_SCALE);
  wire usTick = (usCnt_q == US_LAST);
  wire zeroRef = (duty_q == DUTY_ZERO);
  wire hostZero = (hostCommand == DUTY_ZERO);
  wire inHost = (sourceSelect == SRC_HOST);

  // pin synchroniser; syncB feeds logic, syncC only the rise detect
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      syncC_q <= 1'b0;
    end else begin
      syncA_q <= speedPin;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  // period and high-time measurement in band ticks
  always_ff @(posedge mclk) begin
    if (sys_rst || rise || !srcPin) begin
      prescCnt_q <= PRESC_ZERO;
    end else begin
      prescCnt_q <= tick ? PRESC_ZERO : 8'(prescCnt_q + 8'h01);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hiCnt_q <= CNT_ZERO;
      perCnt_q <= CNT_ZERO;
      hiLat_q <= CNT_ZERO;
      perLat_q <= CNT_ONE;
      measValid_q <= 1'b0;
      stale_q <= 1'b0;
    end else begin
      // a rise that meets a timeout only restarts the measurement
      measValid_q <= rise && !stale_q && !timeout;
      if (rise) begin
        hiLat_q <= hiCnt_q;
        perLat_q <= perCnt_q;
        // the rise cycle is the first high tick of the new period
        hiCnt_q <= CNT_ONE;
        perCnt_q <= CNT_ONE;
        stale_q <= 1'b0;
      end else begin
        if (tick && !perSat) begin
          perCnt_q <= 16'(perCnt_q + CNT_ONE);
        end
        if (tick && syncB_q && !perSat) begin
          hiCnt_q <= 16'(hiCnt_q + CNT_ONE);
        end
        if (timeout) begin
          stale_q <= 1'b1;
        end
      end
    end
  end

  // duty command register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      duty_q <= DUTY_ZERO;
      dutyValid_q <= 1'b0;
      sb_q <= 1'b1;
    end else begin
      dutyValid_q <= update;
      if (update) begin
        duty_q <= dutyNext;
        sb_q <= sbNext;
      end
    end
  end

  // setpoint mapping with deadband
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lastDuty_q <= DUTY_ZERO;
      spd_q <= TGT_ZERO;
      cur_q <= TGT_ZERO;
    end else if (accept) begin
      lastDuty_q <= duty_q;
      spd_q <= (!closed_loop_select && isDirect) ? spdMap : TGT_ZERO;
      cur_q <= (closed_loop_select && isDirect) ? curMap : TGT_ZERO;
    end
  end

  // idle delay timer on a zero reference
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      usCnt_q <= US_ZERO;
      idleCnt_q <= CNT_ZERO;
      idleDone_q <= 1'b0;
    end else begin
      usCnt_q <= usTick ? US_ZERO : 5'(usCnt_q + 5'h01);
      if (inHost ? !hostZero : !zeroRef) begin
        idleCnt_q <= CNT_ZERO;
        idleDone_q <= 1'b0;
      end else if (usTick && !idleDone_q) begin
        if (idleCnt_q >= idleDelayUs) begin
          idleDone_q <= 1'b1;
        end else begin
          idleCnt_q <= 16'(idleCnt_q + CNT_ONE);
        end
      end
    end
  end

  // host-mode power state from command and pin level
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pinLvl_q <= LVL_ZERO;
    end else if (analogValid) begin
      pinLvl_q <= analogLevel;
    end
  end

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      PWR_RUN: begin
        if (inHost && idleDone_q && pinLvl_q < sleep_entry_level) begin
          pwr_d = PWR_SLEEP;
        end else if (inHost && hostCommand <= standby_entry_level &&
                     pinLvl_q > sleep_exit_level) begin
          pwr_d = PWR_STANDBY;
        end
      end
      PWR_STANDBY: begin
        if (!inHost || hostCommand > standby_entry_level) begin
          pwr_d = PWR_RUN;
        end else if (idleDone_q && pinLvl_q < sleep_entry_level) begin
          pwr_d = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (!inHost || pinLvl_q > sleep_exit_level) begin
          pwr_d = PWR_RUN;
        end
      end
      default: pwr_d = PWR_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pwr_q <= PWR_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  assign dutyCmd = duty_q;
  assign dutyValid = dutyValid_q;
  assign speedTarget = spd_q;
  assign currentTarget = cur_q;
  assign speedLoopOn = !closed_loop_select;
  assign currentLoopOn = closed_loop_select;
  assign shapedProfile = !isDirect;
  assign stopReq = inHost ? (pwr_q == PWR_SLEEP) : idleDone_q;
  assign standbyOn = (pwr_q == PWR_STANDBY);
  assign sleepOn = (pwr_q == PWR_SLEEP);

  chk_zero_target: assert property (@(posedge mclk) disable iff (sys_rst)
    (dutyValid_q && duty_q == DUTY_ZERO) |=> (spd_q == TGT_ZERO && cur_q == TGT_ZERO))
    else $error("zero duty did not clear targets");
  chk_deadband_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (dutyValid_q && duty_q != DUTY_ZERO && dutyDiff < command_deadband)
    |=> $stable(spd_q) && $stable(cur_q))
    else $error("target moved inside deadband");
  chk_speed_map: assert property (@(posedge mclk) disable iff (sys_rst)
    (accept && !closed_loop_select && isDirect) |=> (spd_q == $past(spdMap)))
    else $error("speed target mismatch");
  chk_current_map: assert property (@(posedge mclk) disable iff (sys_rst)
    (accept && closed_loop_select && isDirect) |=> (cur_q == $past(curMap)) && spd_q == TGT_ZERO)
    else $error("current target mismatch");
  chk_host_duty: assert property (@(posedge mclk) disable iff (sys_rst)
    (inHost && hostWrite && hostCommand > standby_exit_level) |=> duty_q == $past(hostCommand))
    else $error("host command not taken");
  chk_analog_clamp: assert property (@(posedge mclk) disable iff (sys_rst)
    (sourceSelect == SRC_ANALOG && analogValid && clampAna && !sb_q) |=> duty_q == DUTY_FULL)
    else $error("analog clamp missing");
  chk_standby_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (update && rawDuty <= standby_entry_level) |=> dutyValid_q && duty_q == DUTY_ZERO)
    else $error("standby duty not zero");
  chk_sync_delay: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(syncB_q) |-> $past(speedPin, 2))
    else $error("pin synchroniser depth wrong");
  chk_sleep_wake: assert property (@(posedge mclk) disable iff (sys_rst)
    (pwr_q == PWR_SLEEP && inHost && pinLvl_q > sleep_exit_level) |=> pwr_q == PWR_RUN)
    else $error("sleep exit missed");
  chk_idle_stop: assert property (@(posedge mclk) disable iff (sys_rst)
    (!inHost && !zeroRef) |=> !idleDone_q)
    else $error("stop requested on live reference");
endmodule
